//--- logic/scmc_top.sv
`timescale 1ns/1ns
`default_nettype none
`include "scmc_defines.svh"

// Functional notes
// - The divider chain is a 2-stage prescaler plus a 21-stage divider.
// - Prescaler and divider clear on reset, stop entry and stop exit.
// - A machine cycle is four states, one main clock each.
// - Main clock is the high-frequency clock; machine cycle is four periods.
// - CPU and peripherals both run from the main system clock.
// - Chain yields divider output, time-base, watchdog and timer sources.
// - Chain also times the warm-up after stop wake-up.
// - After reset the device is in run mode, everything clocked.
// - CPU sleep: oscillator on, CPU and watchdog halted, others run.
// - CPU-sleep bit enters it; any interrupt request returns to run.
// - Wake with master enable serves interrupt, else continues next.
// - Clock-gate halt bit enters deep sleep; oscillator on, only time-base keeps clock.
// - Deep sleep ends on falling edge of selected time-base source.
// - Deep sleep entry and exit ignore the time-base enable.
// - Deep sleep entered with time-base enabled sets its latch on exit.
// - Time-base interrupt served only with all three enables at 1.
// - Stop: oscillator off, everything halted, state held.
// - Stop released by pin, level or edge as software selects.
// - After warm-up, execution resumes after the stop instruction.
// - CPU-sleep bit clears itself when CPU sleep ends.
// - Clock-gate halt bit clears itself when deep sleep ends.
// - Reset during stop brings the device back in run mode.
module scmc_top #(
	parameter logic [`SCMC_CHAIN_W-1:0] WARM_3X16 = `SCMC_WARM_3X16,
	parameter logic [`SCMC_CHAIN_W-1:0] WARM_1X16 = `SCMC_WARM_1X16,
	parameter logic [`SCMC_CHAIN_W-1:0] WARM_3X14 = `SCMC_WARM_3X14,
	parameter logic [`SCMC_CHAIN_W-1:0] WARM_1X14 = `SCMC_WARM_1X14
) (
	input wire logic sys_clk_i,
	input wire logic sys_rst_i,
	input wire scmc_pkg::scmc_bus_req_t bus_i,
	output logic [7:0] rdata_o,
	input wire logic stop_pin_i,
	input wire logic irq_req_i,
	input wire logic master_irq_en_i,
	input wire logic tbt_irq_en_i,
	input wire logic tbt_irq_ack_i,
	output scmc_pkg::scmc_clk_en_t clk_en_o,
	output scmc_pkg::scmc_mode_t mode_o,
	output logic [1:0] machine_state_o,
	output logic divider_output_o,
	output logic tbt_src_o,
	output logic wdt_src_o,
	output logic [3:0] timer_src_o,
	output logic tbt_latch_o,
	output logic tbt_service_o,
	output logic wake_service_o,
	output logic wake_resume_o
);

	// ----------------------------------------------------------------
	// Decoding helpers
	// ----------------------------------------------------------------
	function automatic logic [`SCMC_CHAIN_W-1:0] warm_target(
		input logic [1:0] sel
	);
		case (sel)
			2'h0: warm_target = WARM_3X16;
			2'h1: warm_target = WARM_1X16;
			2'h2: warm_target = WARM_3X14;
			default: warm_target = WARM_1X14;
		endcase
	endfunction : warm_target

	function automatic logic tbt_tap(
		input logic [`SCMC_CHAIN_W-1:0] ch,
		input logic [2:0] sel
	);
		case (sel)
			3'h0: tbt_tap = ch[22];
			3'h1: tbt_tap = ch[20];
			3'h2: tbt_tap = ch[15];
			3'h3: tbt_tap = ch[13];
			3'h4: tbt_tap = ch[12];
			3'h5: tbt_tap = ch[11];
			3'h6: tbt_tap = ch[10];
			default: tbt_tap = ch[8];
		endcase
	endfunction : tbt_tap

	function automatic logic is_wr(
		input scmc_pkg::scmc_bus_req_t b,
		input logic [7:0] a
	);
		is_wr = b.wr && (b.addr == a);
	endfunction : is_wr

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	scmc_pkg::scmc_mode_t state_q;
	scmc_pkg::scmc_mode_t state_d;
	logic [7:0] ctrl_one_q;
	logic [7:0] ctrl_two_q;
	logic [7:0] tbt_ctrl_q;
	logic [`SCMC_CHAIN_W-1:0] chain;
	logic chain_clear;
	logic chain_run;
	logic pin_q;
	logic tb_src;
	logic tb_src_q;
	logic tb_fall;
	logic warm_done;
	logic stop_release;
	logic deep_tb_en_q;
	logic leave_cpu_sleep;
	logic leave_deep;
	logic leave_warm;

	assign tb_src = tbt_tap(chain, tbt_ctrl_q[`SCMC_TB_SEL_HI:`SCMC_TB_SEL_LO]);
	assign tb_fall = tb_src_q && !tb_src;
	assign warm_done = chain == (warm_target(
		ctrl_one_q[`SCMC_C1_WUT_HI:`SCMC_C1_WUT_LO]) - 23'h000001);
	// Edge mode waits for a fresh rise; a pin already high is not enough
	assign stop_release = ctrl_one_q[`SCMC_C1_RELM] ? stop_pin_i :
		(stop_pin_i && !pin_q);
	assign leave_cpu_sleep = (state_q == scmc_pkg::SCMC_CPU_SLEEP) &&
		irq_req_i;
	assign leave_deep = (state_q == scmc_pkg::SCMC_DEEP_SLEEP) && tb_fall;
	assign leave_warm = (state_q == scmc_pkg::SCMC_WARMUP) && warm_done;

	// ----------------------------------------------------------------
	// Divider chain
	// ----------------------------------------------------------------
	// The chain stops with the oscillator in stop mode
	assign chain_run = state_q != scmc_pkg::SCMC_STOP;
	assign chain_clear = (state_q != state_d) &&
		(state_q == scmc_pkg::SCMC_STOP ||
		state_d == scmc_pkg::SCMC_STOP ||
		state_d == scmc_pkg::SCMC_WARMUP);

	scmc_divider_chain u_chain (
		.sys_clk_i(sys_clk_i),
		.sys_rst_i(sys_rst_i),
		.clear_i(chain_clear),
		.run_i(chain_run),
		.chain_o(chain)
	);

	// ----------------------------------------------------------------
	// Operating mode sequencer
	// ----------------------------------------------------------------
	always_comb begin
		state_d = state_q;
		case (state_q)
			scmc_pkg::SCMC_RUN: begin
				if (ctrl_one_q[`SCMC_C1_STOP]) begin
					// Level mode with the pin already high skips stop
					state_d = (ctrl_one_q[`SCMC_C1_RELM] && stop_pin_i) ?
						scmc_pkg::SCMC_WARMUP : scmc_pkg::SCMC_STOP;
				end else if (ctrl_two_q[`SCMC_C2_IDLE]) begin
					state_d = scmc_pkg::SCMC_CPU_SLEEP;
				end else if (ctrl_two_q[`SCMC_C2_CLOCK_GATE_HALT_BIT]) begin
					state_d = scmc_pkg::SCMC_DEEP_SLEEP;
				end
			end
			scmc_pkg::SCMC_CPU_SLEEP: begin
				if (leave_cpu_sleep) begin
					state_d = scmc_pkg::SCMC_RUN;
				end
			end
			scmc_pkg::SCMC_DEEP_SLEEP: begin
				if (leave_deep) begin
					state_d = scmc_pkg::SCMC_RUN;
				end
			end
			scmc_pkg::SCMC_STOP: begin
				if (stop_release) begin
					state_d = scmc_pkg::SCMC_WARMUP;
				end
			end
			scmc_pkg::SCMC_WARMUP: begin
				if (leave_warm) begin
					state_d = scmc_pkg::SCMC_RUN;
				end
			end
			default: state_d = scmc_pkg::SCMC_RUN;
		endcase
	end

	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			state_q <= scmc_pkg::SCMC_RUN;
		end else begin
			state_q <= state_d;
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			pin_q <= 1'b0;
			tb_src_q <= 1'b0;
		end else begin
			pin_q <= stop_pin_i;
			tb_src_q <= tb_src;
		end
	end

	// ----------------------------------------------------------------
	// Control registers
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			ctrl_one_q <= `SCMC_C1_RST;
		end else begin
			if (is_wr(bus_i, `SCMC_ADDR_CTRL_ONE)) begin
				ctrl_one_q <= bus_i.wdata;
			end
			// Stop request is spent once execution resumes
			if (leave_warm) begin
				ctrl_one_q[`SCMC_C1_STOP] <= 1'b0;
			end
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			ctrl_two_q <= `SCMC_C2_RST;
		end else begin
			if (is_wr(bus_i, `SCMC_ADDR_CTRL_TWO)) begin
				ctrl_two_q <= bus_i.wdata;
			end
			if (leave_cpu_sleep) begin
				ctrl_two_q[`SCMC_C2_IDLE] <= 1'b0;
			end
			if (leave_deep) begin
				ctrl_two_q[`SCMC_C2_CLOCK_GATE_HALT_BIT] <= 1'b0;
			end
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			tbt_ctrl_q <= `SCMC_TB_RST;
		end else if (is_wr(bus_i, `SCMC_ADDR_TBT_CTRL)) begin
			tbt_ctrl_q <= bus_i.wdata;
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			rdata_o <= 8'h00;
		end else if (bus_i.rd) begin
			case (bus_i.addr)
				`SCMC_ADDR_CTRL_ONE: rdata_o <= ctrl_one_q;
				`SCMC_ADDR_CTRL_TWO: rdata_o <= ctrl_two_q;
				`SCMC_ADDR_TBT_CTRL: rdata_o <= tbt_ctrl_q;
				`SCMC_ADDR_STATUS: rdata_o <= {tbt_latch_o, 4'h0, state_q};
				default: rdata_o <= 8'h00;
			endcase
		end else begin
			rdata_o <= 8'h00;
		end
	end

	// ----------------------------------------------------------------
	// Time-base interrupt latch
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			deep_tb_en_q <= 1'b0;
		end else if (state_q == scmc_pkg::SCMC_RUN &&
			state_d == scmc_pkg::SCMC_DEEP_SLEEP) begin
			deep_tb_en_q <= tbt_ctrl_q[`SCMC_TB_EN];
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			tbt_latch_o <= 1'b0;
		end else if (leave_deep && deep_tb_en_q) begin
			// Set wins over a same-cycle acknowledge
			tbt_latch_o <= 1'b1;
		end else if (tbt_irq_ack_i) begin
			tbt_latch_o <= 1'b0;
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			tbt_service_o <= 1'b0;
		end else begin
			tbt_service_o <= tbt_latch_o && master_irq_en_i &&
				tbt_irq_en_i && tbt_ctrl_q[`SCMC_TB_EN];
		end
	end

	// ----------------------------------------------------------------
	// Wake-up outcome from CPU sleep
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			wake_service_o <= 1'b0;
			wake_resume_o <= 1'b0;
		end else begin
			wake_service_o <= leave_cpu_sleep && master_irq_en_i;
			wake_resume_o <= leave_cpu_sleep && !master_irq_en_i;
		end
	end

	// ----------------------------------------------------------------
	// Clock gating and machine cycle
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			clk_en_o <= 5'h1F;
			mode_o <= scmc_pkg::SCMC_RUN;
		end else begin
			mode_o <= state_d;
			clk_en_o.osc <= state_d != scmc_pkg::SCMC_STOP;
			clk_en_o.cpu <= state_d == scmc_pkg::SCMC_RUN;
			clk_en_o.wdt <= state_d == scmc_pkg::SCMC_RUN;
			clk_en_o.periph <= state_d == scmc_pkg::SCMC_RUN ||
				state_d == scmc_pkg::SCMC_CPU_SLEEP;
			clk_en_o.time_base_timer <= state_d == scmc_pkg::SCMC_RUN ||
				state_d == scmc_pkg::SCMC_CPU_SLEEP ||
				state_d == scmc_pkg::SCMC_DEEP_SLEEP;
		end
	end

	// Main clock equals the high-frequency clock, one state per cycle
	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			machine_state_o <= 2'h0;
		end else if (state_d == scmc_pkg::SCMC_RUN) begin
			machine_state_o <= machine_state_o + 2'h1;
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			divider_output_o <= 1'b0;
			tbt_src_o <= 1'b0;
			wdt_src_o <= 1'b0;
			timer_src_o <= 4'h0;
		end else begin
			divider_output_o <= chain[`SCMC_DVO_BIT] &&
				state_q != scmc_pkg::SCMC_DEEP_SLEEP;
			tbt_src_o <= tb_src;
			wdt_src_o <= chain[`SCMC_WDT_BIT] &&
				state_q == scmc_pkg::SCMC_RUN;
			timer_src_o <= (state_q == scmc_pkg::SCMC_RUN ||
				state_q == scmc_pkg::SCMC_CPU_SLEEP) ?
				{chain[11], chain[7], chain[5], chain[3]} : 4'h0;
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (sys_rst_i);

	chain_clear_stop_a: assert property (
		state_q == scmc_pkg::SCMC_RUN && state_d == scmc_pkg::SCMC_STOP
		|=> chain == 23'h000000) else $error("chain not cleared");
	stop_holds_a: assert property (
		state_q == scmc_pkg::SCMC_STOP && !stop_release
		|=> state_q == scmc_pkg::SCMC_STOP && $stable(chain))
		else $error("stop not held");
	machine_cycle_a: assert property (
		state_q == scmc_pkg::SCMC_RUN && state_d == scmc_pkg::SCMC_RUN
		|=> machine_state_o == $past(machine_state_o) + 2'h1)
		else $error("machine state skipped");
	cpu_sleep_gate_a: assert property (
		state_q == scmc_pkg::SCMC_CPU_SLEEP |-> clk_en_o.osc &&
		!clk_en_o.cpu && !clk_en_o.wdt && clk_en_o.periph)
		else $error("cpu sleep gating wrong");
	deep_gate_a: assert property (
		state_q == scmc_pkg::SCMC_DEEP_SLEEP |-> clk_en_o.time_base_timer &&
		!clk_en_o.periph && !clk_en_o.cpu) else $error("deep gating wrong");
	idle_clear_a: assert property (
		leave_cpu_sleep |=> !ctrl_two_q[`SCMC_C2_IDLE] &&
		state_q == scmc_pkg::SCMC_RUN) else $error("idle bit kept");
	halt_clear_a: assert property (
		leave_deep |=> !ctrl_two_q[`SCMC_C2_CLOCK_GATE_HALT_BIT] &&
		state_q == scmc_pkg::SCMC_RUN) else $error("halt bit kept");
	deep_latch_a: assert property (
		leave_deep && deep_tb_en_q |=> tbt_latch_o)
		else $error("time-base latch not set");
	wake_path_a: assert property (
		leave_cpu_sleep |=> wake_service_o == $past(master_irq_en_i) &&
		wake_resume_o != $past(master_irq_en_i)) else $error("wake path");
	warm_hold_a: assert property (
		state_q == scmc_pkg::SCMC_WARMUP && !warm_done
		|=> !clk_en_o.cpu && !clk_en_o.periph) else $error("early resume");
	level_skip_a: assert property (
		state_q == scmc_pkg::SCMC_RUN && ctrl_one_q[`SCMC_C1_STOP] &&
		ctrl_one_q[`SCMC_C1_RELM] && stop_pin_i
		|=> state_q == scmc_pkg::SCMC_WARMUP) else $error("level skip");

	stop_cycle_c: cover property (state_q == scmc_pkg::SCMC_WARMUP &&
		warm_done);
	cpu_sleep_c: cover property (leave_cpu_sleep);
	deep_sleep_c: cover property (leave_deep && deep_tb_en_q);

endmodule : scmc_top

`default_nettype wire

//--- logic/scmc_defines.svh
`ifndef SCMC_DEFINES_SVH
`define SCMC_DEFINES_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define SCMC_ADDR_CTRL_ONE 8'h00
`define SCMC_ADDR_CTRL_TWO 8'h01
`define SCMC_ADDR_TBT_CTRL 8'h02
`define SCMC_ADDR_STATUS 8'h03

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define SCMC_C1_STOP 7
`define SCMC_C1_RELM 6
`define SCMC_C1_WUT_HI 3
`define SCMC_C1_WUT_LO 2
`define SCMC_C2_IDLE 4
`define SCMC_C2_CLOCK_GATE_HALT_BIT 2
`define SCMC_TB_EN 7
`define SCMC_TB_SEL_HI 2
`define SCMC_TB_SEL_LO 0
`define SCMC_ST_LATCH 7

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define SCMC_C1_RST 8'h00
`define SCMC_C2_RST 8'h00
`define SCMC_TB_RST 8'h00

// ----------------------------------------------------------------
// Divider chain and timing counts, in high-frequency clock cycles
// ----------------------------------------------------------------
`define SCMC_PRE_W 2
`define SCMC_DIV_W 21
`define SCMC_CHAIN_W 23
`define SCMC_WARM_3X16 23'h030000
`define SCMC_WARM_1X16 23'h010000
`define SCMC_WARM_3X14 23'h00C000
`define SCMC_WARM_1X14 23'h004000
`define SCMC_DVO_BIT 13
`define SCMC_WDT_BIT 15

`endif

//--- logic/scmc_pkg.sv
package scmc_pkg;

	typedef enum logic [2:0] {
		SCMC_RUN,
		SCMC_CPU_SLEEP,
		SCMC_DEEP_SLEEP,
		SCMC_STOP,
		SCMC_WARMUP
	} scmc_mode_t;

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} scmc_bus_req_t;

	typedef struct packed {
		logic osc;
		logic cpu;
		logic wdt;
		logic periph;
		logic time_base_timer;
	} scmc_clk_en_t;

endpackage : scmc_pkg

//--- logic/scmc_divider_chain.sv
`timescale 1ns/1ns
`default_nettype none
`include "scmc_defines.svh"

module scmc_divider_chain (
	input wire logic sys_clk_i,
	input wire logic sys_rst_i,
	input wire logic clear_i,
	input wire logic run_i,
	output logic [`SCMC_CHAIN_W-1:0] chain_o
);

	logic [`SCMC_CHAIN_W-1:0] chain_q;
	logic [`SCMC_CHAIN_W:0] carry;

	assign carry[0] = run_i;

	// ----------------------------------------------------------------
	// Prescaler stages followed by divider stages
	// ----------------------------------------------------------------
	genvar i;
	generate
		for (i = 0; i < `SCMC_CHAIN_W; i++) begin : g_stage
			assign carry[i+1] = carry[i] & chain_q[i];
			always_ff @(posedge sys_clk_i) begin
				if (sys_rst_i || clear_i) begin
					chain_q[i] <= 1'b0;
				end else if (carry[i]) begin
					chain_q[i] <= ~chain_q[i];
				end
			end
		end
	endgenerate

	assign chain_o = chain_q;

endmodule : scmc_divider_chain

`default_nettype wire

//--- sim/scmc_far_side.sv
`timescale 1ns/1ns
`default_nettype none

// ----------------------------------------------------------------
// CPU core, peripherals and stop-release pin seen from the block
// ----------------------------------------------------------------
module scmc_far_side (
	input wire logic sys_clk_i,
	output logic stop_pin_o,
	output logic irq_req_o,
	output logic master_irq_en_o,
	output logic tbt_irq_en_o,
	output logic tbt_irq_ack_o
);
	initial begin
		stop_pin_o = 1'b0;
		irq_req_o = 1'b0;
		master_irq_en_o = 1'b0;
		tbt_irq_en_o = 1'b0;
		tbt_irq_ack_o = 1'b0;
	end

	// One-cycle request; returns just after the edge that sampled it, so
	// the caller sees the wake pulses while they stand
	task automatic raise_irq();
		@(posedge sys_clk_i);
		irq_req_o <= 1'b1;
		@(posedge sys_clk_i);
		irq_req_o <= 1'b0;
		#1;
	endtask : raise_irq

	// Level or edge release is the caller's choice of pin sequence
	task automatic set_pin(input logic v);
		@(posedge sys_clk_i);
		stop_pin_o <= v;
	endtask : set_pin

	task automatic set_en(input logic m, input logic t);
		@(posedge sys_clk_i);
		master_irq_en_o <= m;
		tbt_irq_en_o <= t;
	endtask : set_en

	task automatic ack();
		@(posedge sys_clk_i);
		tbt_irq_ack_o <= 1'b1;
		@(posedge sys_clk_i);
		tbt_irq_ack_o <= 1'b0;
	endtask : ack
endmodule : scmc_far_side

`default_nettype wire

//--- sim/tb.sv
`timescale 1ns/1ns
`default_nettype none

`define CHK(g, e) chk(32'(g), 32'(e))

module tb;
	logic sys_clk_i = 1'b0;
	logic sys_rst_i = 1'b1;
	scmc_pkg::scmc_bus_req_t bus = '0;
	logic [7:0] rdata;
	logic stop_pin, irq_req, m_en, t_en, t_ack;
	scmc_pkg::scmc_clk_en_t clk_en;
	scmc_pkg::scmc_mode_t mode;
	logic [1:0] ms;
	logic divider_output, tsrc, wsrc, latch, serv, wsv, wrs;
	logic [3:0] tmr;
	int mismatches = 0;
	int checked = 0;
	logic [7:0] got;
	int n;
	// Address, write data, expected read back
	logic [23:0] rows [7] = '{24'h004C4C, 24'h000808, 24'h028787,
		24'h020505, 24'h010000, 24'h10FF00, 24'h03FF00};
	// Warm-up lengths for the shortened counts handed to the design
	localparam int warm_c [4] = '{64, 32, 24, 16};

	always #4 sys_clk_i = ~sys_clk_i;

	scmc_top #(
		.WARM_3X16(23'(warm_c[0])),
		.WARM_1X16(23'(warm_c[1])),
		.WARM_3X14(23'(warm_c[2])),
		.WARM_1X14(23'(warm_c[3]))
	) dut_u (
		.sys_clk_i(sys_clk_i),
		.sys_rst_i(sys_rst_i),
		.bus_i(bus),
		.rdata_o(rdata),
		.stop_pin_i(stop_pin),
		.irq_req_i(irq_req),
		.master_irq_en_i(m_en),
		.tbt_irq_en_i(t_en),
		.tbt_irq_ack_i(t_ack),
		.clk_en_o(clk_en),
		.mode_o(mode),
		.machine_state_o(ms),
		.divider_output_o(divider_output),
		.tbt_src_o(tsrc),
		.wdt_src_o(wsrc),
		.timer_src_o(tmr),
		.tbt_latch_o(latch),
		.tbt_service_o(serv),
		.wake_service_o(wsv),
		.wake_resume_o(wrs)
	);

	scmc_far_side far_u (
		.sys_clk_i(sys_clk_i),
		.stop_pin_o(stop_pin),
		.irq_req_o(irq_req),
		.master_irq_en_o(m_en),
		.tbt_irq_en_o(t_en),
		.tbt_irq_ack_o(t_ack)
	);

	// ----------------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------------
	task automatic tally_and_finish();
		$display("checked %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : tally_and_finish

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		checked++;
		if (g !== e) begin
			mismatches++;
			$display("Error at %0t: got %0h expected %0h", $time, g, e);
		end
	endtask : chk

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge sys_clk_i);
		bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge sys_clk_i);
		bus.wr <= 1'b0;
	endtask : wr

	// Read data stand only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge sys_clk_i);
		bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge sys_clk_i);
		bus.rd <= 1'b0;
		#1 d = rdata;
	endtask : rd

	task automatic wait_mode(input scmc_pkg::scmc_mode_t m, input int lim,
		output int c);
		c = 0;
		while (mode !== m) begin
			@(posedge sys_clk_i);
			#1 c++;
			if (c > lim) begin
				mismatches++;
				$display("Error at %0t: mode %0h expected %0h", $time, mode, m);
				tally_and_finish();
			end
		end
	endtask : wait_mode

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		repeat (15) @(posedge sys_clk_i);
		#1 `CHK(mode, scmc_pkg::SCMC_RUN);
		`CHK(clk_en, 5'h1F);
		`CHK({ms, tmr, divider_output, wsrc}, 8'h00);
		@(posedge sys_clk_i);
		sys_rst_i <= 1'b0;
		foreach (rows[i]) begin
			wr(rows[i][23:16], rows[i][15:8]);
			rd(rows[i][23:16], got);
			`CHK(got, rows[i][7:0]);
		end
		for (int i = 0; i < 8; i++) begin
			got[1:0] = ms + 2'h1;
			@(posedge sys_clk_i);
			#1 `CHK(ms, got[1:0]);
		end
		// First pass syncs to a toggle, second measures its spacing
		for (int k = 0; k < 2; k++) begin
			got[0] = tmr[0];
			n = 0;
			while (tmr[0] === got[0] && n < 20) begin
				@(posedge sys_clk_i);
				#1 n++;
			end
		end
		`CHK(n, 8);
		if (n >= 20) begin
			tally_and_finish();
		end
		for (int k = 0; k < 2; k++) begin
			far_u.set_en(k[0], 1'b0);
			wr(8'h01, 8'h10);
			wait_mode(scmc_pkg::SCMC_CPU_SLEEP, 3, n);
			`CHK(clk_en, 5'h13);
			repeat (4) @(posedge sys_clk_i);
			#1 `CHK(mode, scmc_pkg::SCMC_CPU_SLEEP);
			far_u.raise_irq();
			wait_mode(scmc_pkg::SCMC_RUN, 3, n);
			`CHK({wsv, wrs}, k ? 2'b10 : 2'b01);
			@(posedge sys_clk_i);
			#1 `CHK({wsv, wrs}, 2'b00);
			rd(8'h01, got);
			`CHK(got[4], 1'b0);
		end
		// Deep sleep with the time-base on, then off
		for (int k = 1; k >= 0; k--) begin
			far_u.set_en(1'b1, 1'b1);
			wr(8'h02, {k[0], 7'h07});
			wr(8'h01, 8'h04);
			wait_mode(scmc_pkg::SCMC_DEEP_SLEEP, 3, n);
			`CHK({clk_en, divider_output}, 6'h22);
			// Catch the source high so the exit must follow its fall
			n = 0;
			while (tsrc !== 1'b1 && n < 600) begin
				@(posedge sys_clk_i);
				#1 n++;
			end
			`CHK({mode, n < 600}, {scmc_pkg::SCMC_DEEP_SLEEP, 1'b1});
			if (n >= 600) begin
				tally_and_finish();
			end
			wait_mode(scmc_pkg::SCMC_RUN, 260, n);
			`CHK({clk_en, tsrc}, 6'h3E);
			repeat (2) @(posedge sys_clk_i);
			#1 `CHK({latch, serv}, {k[0], k[0]});
			far_u.set_en(1'b1, 1'b0);
			repeat (2) @(posedge sys_clk_i);
			#1 `CHK({latch, serv}, {k[0], 1'b0});
			far_u.ack();
			rd(8'h01, got);
			`CHK({latch, got[2]}, 2'b00);
		end
		for (int i = 0; i < 4; i++) begin
			wr(8'h00, {4'hC, i[1:0], 2'b00});
			wait_mode(scmc_pkg::SCMC_STOP, 3, n);
			got[1:0] = ms;
			repeat (5) @(posedge sys_clk_i);
			#1 `CHK({clk_en, ms}, {5'h00, got[1:0]});
			far_u.set_pin(1'b1);
			wait_mode(scmc_pkg::SCMC_WARMUP, 3, n);
			`CHK({clk_en.cpu, clk_en.periph}, 2'b00);
			wait_mode(scmc_pkg::SCMC_RUN, 200, n);
			`CHK(n >= warm_c[i] - 1 && n <= warm_c[i] + 1, 1'b1);
			far_u.set_pin(1'b0);
			rd(8'h00, got);
			`CHK(got[7], 1'b0);
		end
		// Level release with the pin already high never settles in stop
		far_u.set_pin(1'b1);
		wr(8'h00, 8'hCC);
		wait_mode(scmc_pkg::SCMC_WARMUP, 3, n);
		wait_mode(scmc_pkg::SCMC_RUN, 200, n);
		// Edge release ignores a pin that is merely high
		wr(8'h00, 8'h8C);
		wait_mode(scmc_pkg::SCMC_STOP, 3, n);
		repeat (6) @(posedge sys_clk_i);
		#1 `CHK(mode, scmc_pkg::SCMC_STOP);
		far_u.set_pin(1'b0);
		repeat (3) @(posedge sys_clk_i);
		#1 `CHK(mode, scmc_pkg::SCMC_STOP);
		far_u.set_pin(1'b1);
		wait_mode(scmc_pkg::SCMC_WARMUP, 4, n);
		wait_mode(scmc_pkg::SCMC_RUN, 200, n);
		`CHK(n >= 15 && n <= 17, 1'b1);
		far_u.set_pin(1'b0);
		wr(8'h00, 8'hCC);
		wait_mode(scmc_pkg::SCMC_STOP, 3, n);
		@(posedge sys_clk_i);
		sys_rst_i <= 1'b1;
		@(posedge sys_clk_i);
		sys_rst_i <= 1'b0;
		wait_mode(scmc_pkg::SCMC_RUN, 3, n);
		#1 `CHK(clk_en, 5'h1F);
		rd(8'h00, got);
		`CHK(got, 8'h00);
		tally_and_finish();
	end
endmodule : tb

`default_nettype wire
